/* ioa_pkg.sv */
// constants and types for the indexed operand addressing datapath
package ioa_pkg;

  // ****************************************************************
  // register map, byte addresses on the wishbone slave
  // ****************************************************************
  localparam logic [7:0] REG_PSW     = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_OPADDR  = 8'h08;
  localparam logic [2:0] STACK_PAGE  = 3'h1;

  // ****************************************************************
  // process state word layout (bit 0 is the least significant)
  // ****************************************************************
  localparam int unsigned PSW_RP_LSB  = 0;
  localparam int unsigned PSW_CS      = 8;
  localparam int unsigned PSW_DS      = 9;
  localparam int unsigned PSW_ELEVATED_MODE_FLAG    = 10;
  localparam int unsigned PSW_LS      = 11;
  localparam int unsigned PSW_UF_LSB  = 12;
  localparam logic [15:0] PSW_RESET   = 16'h0007;

  // ****************************************************************
  // status register layout
  // ****************************************************************
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_FSM_LSB  = 1;
  localparam int unsigned ST_SAVE_LSB = 3;

  // ****************************************************************
  // index selection and element sizes
  // ****************************************************************
  localparam logic [2:0] INDEX_REG_BASE = 3'h4;
  localparam logic [2:0] WORD_STEP      = 3'h1;
  localparam logic [2:0] DWORD_STEP     = 3'h2;

  typedef enum logic [1:0] {SIZE_WORD, SIZE_BYTE, SIZE_DWORD} size_type;
  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_OPND, ST_OPND2} fsm_type;

endpackage

/* indexed_operand_addressing.sv */
// indexed operand address generation, register stack and state word
// ******************************************************************
// Summary of operation
// RQ1: index is signed 16 bit, addresses wrap
// RQ2: index field 0 none, 1..3 select registers 5..7
// RQ3: index counts in operand element units
// RQ4: direct word: direct address plus index
// RQ5: indirect word: pointer read, then plus index
// RQ6: direct byte: twice direct plus index, split lanes
// RQ7: indirect byte: byte pointer plus index, same split
// RQ8: direct doubleword: direct plus twice index, two words
// RQ9: indirect doubleword: pointer plus twice index
// RQ10: eight 16-bit stack registers, 5..7 index
// RQ11: pointer up on loads, down on stores/arithmetic
// RQ12: pointer 7 is empty and full, wraps freely
// RQ13: elements addressed downward from pointer modulo eight
// RQ14: state word saved on call/interrupt, restored on return
// RQ15: top four state bits are microcode-only flags
// RQ16: library bit selects library code segment
// RQ17: privileged work without elevated mode traps
// RQ18: callable procedure runs privileged, caller restored after
// RQ19: data area bit picks data segment; system base privileged
// RQ20: code area bit with library bit picks code segment
// RQ21: indirect pointer read completes before operand access
// ******************************************************************
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

module indexed_operand_addressing
  import ioa_pkg::*;
#(
  parameter int unsigned SAVE_DEPTH = 8
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [7:0]  adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] dat_wr,
  output logic      [31:0] dat_rd,
  output logic             ack,
  // instruction decode
  input  wire logic        op_start,
  input  wire logic        op_store,
  input  wire logic        op_indirect,
  input  wire size_type    op_size,
  input  wire logic [1:0]  op_index_sel,
  input  wire logic [15:0] op_direct_addr,
  input  wire logic        op_system_base,
  input  wire logic        op_privileged,
  input  wire logic        alu_pop,
  input  wire logic        alu_pop_dword,
  input  wire logic        call_start,
  input  wire logic        call_callable,
  input  wire logic        call_privileged,
  input  wire logic        ret_start,
  input  wire logic        intr_start,
  output logic             op_busy,
  output logic             op_done,
  output logic             instruction_failure_trap,
  // data memory
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic      [1:0]  mem_be,
  output logic             mem_system_data,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // segment selection
  output logic      [1:0]  code_segment,
  output logic      [15:0] process_state_word
);

  localparam int unsigned SP_W = (SAVE_DEPTH > 1) ? $clog2(SAVE_DEPTH) : 1;

  typedef struct packed {
    fsm_type                        fsm;
    logic                           busy;
    logic                           store;
    size_type                       size;
    logic [15:0]                    index;
    logic [15:0]                    addr;
    logic                           lane;
    logic [15:0]                    first;
    logic [7:0][15:0]               stack;
    logic [15:0]                    psw;
    logic [SAVE_DEPTH-1:0][15:0]    saves;
    logic [SP_W-1:0]                save_ptr;
    logic                           mem_req;
    logic                           mem_we;
    logic [15:0]                    mem_addr;
    logic [15:0]                    mem_wdata;
    logic [1:0]                     mem_be;
    logic                           mem_sys;
    logic                           done;
    logic                           trap;
    logic [1:0]                     code_seg;
    logic                           ack;
    logic [31:0]                    rdat;
  } state_type;

  state_type s;
  state_type next_s;

  logic [2:0]  rp;
  logic        elevated_mode_flag;
  logic [15:0] x_now;
  logic [15:0] byte_ba;
  logic        stack_hit;
  logic [31:0] rd_value;
  logic        ctl_free;
  logic        start_ok;

  assign rp        = s.psw[PSW_RP_LSB +: 3];
  assign elevated_mode_flag      = s.psw[PSW_ELEVATED_MODE_FLAG];
  assign x_now     = (op_index_sel == 2'h0) ? 16'h0000 :
                     s.stack[3'(op_index_sel) + INDEX_REG_BASE]; // RQ2
  assign byte_ba   = {op_direct_addr[14:0], 1'b0} + x_now;
  assign stack_hit = (adr[7:5] == STACK_PAGE) && (adr[1:0] == 2'h0);
  assign ctl_free  = (s.fsm == ST_IDLE) && !intr_start && !call_start &&
                     !ret_start;
  assign start_ok  = ctl_free && op_start &&
                     !((op_privileged || op_system_base) && !elevated_mode_flag);

  // ****************************************************************
  // register read mux
  // ****************************************************************
  assign rd_value = (adr == REG_PSW)    ? {16'h0000, s.psw} :
                    (adr == REG_STATUS) ? 32'({s.save_ptr, s.fsm, s.busy}) :
                    (adr == REG_OPADDR) ? {16'h0000, s.addr} :
                    stack_hit ? {16'h0000, s.stack[adr[4:2]]} :
                    32'h0000_0000;

  function automatic logic [15:0] merge16(logic [15:0] old,
                                          logic [31:0] d,
                                          logic [3:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = d[7:0];
    end
    if (be[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // effective address: word address in [16:1], byte lane in [0]
  // the 16-bit sum drops the carry, so every address wraps
  function automatic logic [16:0] ea(logic [15:0] base,
                                     logic [15:0] x,
                                     size_type    size,
                                     logic        ind);
    logic [15:0] ba;
    ba = 16'h0000;
    unique case (size)
      SIZE_BYTE:
      begin
        ba = ind ? base + x : {base[14:0], 1'b0} + x; // RQ6 RQ7 RQ3
        return {1'b0, ba[15:1], ba[0]};
      end
      SIZE_DWORD:
        return {base + {x[14:0], 1'b0}, 1'b0}; // RQ8 RQ9 RQ3
      default:
        return {base + x, 1'b0}; // RQ4 RQ5 RQ1
    endcase
  endfunction

  // launch the operand access for an already latched operation
  function automatic state_type issue(state_type t, logic [16:0] a);
    state_type r;
    logic [2:0] p;
    r = t;
    p = r.psw[PSW_RP_LSB +: 3];
    r.addr      = a[16:1];
    r.lane      = a[0];
    r.mem_req   = 1'b1;
    r.mem_addr  = a[16:1];
    r.mem_we    = r.store;
    r.mem_be    = 2'h3;
    r.mem_wdata = r.stack[p];
    r.fsm       = ST_OPND;
    if (r.size == SIZE_BYTE)
    begin
      // right byte is the low lane of the word
      r.mem_wdata = {r.stack[p][7:0], r.stack[p][7:0]};
      r.mem_be    = a[0] ? 2'h1 : 2'h2; // RQ6
    end
    else if (r.size == SIZE_DWORD)
    begin
      r.mem_wdata = r.stack[3'(p - WORD_STEP)]; // RQ13
    end
    return r;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    next_s.trap = 1'b0;
    next_s.ack  = 1'b0;

    // stack and state word writes are ignored while an access runs
    if (cyc && stb && !s.ack)
    begin
      next_s.ack  = 1'b1;
      next_s.rdat = rd_value;
      if (we && (s.fsm == ST_IDLE))
      begin
        if (adr == REG_PSW)
        begin
          next_s.psw = merge16(s.psw, dat_wr, sel);
        end
        else if (stack_hit)
        begin
          next_s.stack[adr[4:2]] =
            merge16(s.stack[adr[4:2]], dat_wr, sel); // RQ10
        end
      end
    end

    unique case (s.fsm)
      ST_IDLE:
      begin
        if (intr_start)
        begin
          next_s.saves[s.save_ptr] = s.psw; // RQ14
          next_s.save_ptr = SP_W'(s.save_ptr + 1'b1);
          next_s.psw[PSW_ELEVATED_MODE_FLAG] = 1'b1;
          next_s.psw[PSW_DS]   = 1'b1;
          next_s.psw[PSW_CS]   = 1'b1;
        end
        else if (call_start)
        begin
          if (call_privileged && !elevated_mode_flag)
          begin
            next_s.trap = 1'b1; // RQ17
          end
          else
          begin
            next_s.saves[s.save_ptr] = s.psw; // RQ14
            next_s.save_ptr = SP_W'(s.save_ptr + 1'b1);
            if (call_callable)
            begin
              next_s.psw[PSW_ELEVATED_MODE_FLAG] = 1'b1; // RQ18
            end
          end
        end
        else if (ret_start)
        begin
          // caller state comes back whole, privilege included
          next_s.save_ptr = SP_W'(s.save_ptr - 1'b1);
          next_s.psw = s.saves[SP_W'(s.save_ptr - 1'b1)]; // RQ14 RQ18
        end
        else if (op_start)
        begin
          next_s.store = op_store;
          next_s.size  = op_size;
          next_s.index = x_now; // RQ2
          if ((op_privileged || op_system_base) && !elevated_mode_flag)
          begin
            next_s.trap = 1'b1; // RQ17
          end
          else
          begin
            next_s.busy    = 1'b1;
            next_s.mem_sys = s.psw[PSW_DS] | op_system_base; // RQ19
            if (op_indirect)
            begin
              next_s.mem_req  = 1'b1; // RQ21
              next_s.mem_we   = 1'b0;
              next_s.mem_be   = 2'h3;
              next_s.mem_addr = op_direct_addr;
              next_s.fsm      = ST_PTR;
            end
            else
            begin
              next_s = issue(next_s,
                             ea(op_direct_addr, x_now, op_size, 1'b0));
            end
          end
        end
        else if (alu_pop)
        begin
          next_s.psw[PSW_RP_LSB +: 3] =
            rp - (alu_pop_dword ? DWORD_STEP : WORD_STEP); // RQ11
        end
      end
      ST_PTR:
      begin
        if (mem_ack)
        begin
          // pointer in hand: operand access follows at once
          next_s = issue(next_s,
                         ea(mem_rdata, s.index, s.size, 1'b1)); // RQ21
        end
      end
      ST_OPND:
      begin
        if (mem_ack)
        begin
          if (s.size == SIZE_DWORD)
          begin
            next_s.first     = mem_rdata;
            next_s.mem_addr  = s.mem_addr + 16'h0001; // RQ8 RQ9
            next_s.mem_wdata = s.stack[rp];
            next_s.fsm       = ST_OPND2;
          end
          else
          begin
            if (s.store)
            begin
              next_s.psw[PSW_RP_LSB +: 3] = rp - WORD_STEP; // RQ11
            end
            else
            begin
              next_s.psw[PSW_RP_LSB +: 3] = rp + WORD_STEP; // RQ11 RQ12
              next_s.stack[3'(rp + WORD_STEP)] =
                (s.size == SIZE_BYTE) ?
                {8'h00, s.lane ? mem_rdata[7:0] : mem_rdata[15:8]} :
                mem_rdata; // RQ6
            end
            next_s.mem_req = 1'b0;
            next_s.mem_we  = 1'b0;
            next_s.busy    = 1'b0;
            next_s.done    = 1'b1;
            next_s.fsm     = ST_IDLE;
          end
        end
      end
      ST_OPND2:
      begin
        if (mem_ack)
        begin
          if (s.store)
          begin
            next_s.psw[PSW_RP_LSB +: 3] = rp - DWORD_STEP; // RQ11
          end
          else
          begin
            next_s.psw[PSW_RP_LSB +: 3] = rp + DWORD_STEP; // RQ11 RQ12
            next_s.stack[3'(rp + WORD_STEP)] = s.first; // RQ13
            next_s.stack[3'(rp + DWORD_STEP)] = mem_rdata;
          end
          next_s.mem_req = 1'b0;
          next_s.mem_we  = 1'b0;
          next_s.busy    = 1'b0;
          next_s.done    = 1'b1;
          next_s.fsm     = ST_IDLE;
        end
      end
    endcase

    // top flag nibble is carried but steers nothing
    next_s.code_seg = {next_s.psw[PSW_CS], next_s.psw[PSW_LS]}; // RQ16 RQ20
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s     <= '0;
      s.psw <= PSW_RESET; // RQ12 RQ15
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign dat_rd                   = s.rdat;
  assign ack                      = s.ack;
  assign op_busy                  = s.busy;
  assign op_done                  = s.done;
  assign instruction_failure_trap = s.trap;
  assign mem_req                  = s.mem_req;
  assign mem_we                   = s.mem_we;
  assign mem_addr                 = s.mem_addr;
  assign mem_wdata                = s.mem_wdata;
  assign mem_be                   = s.mem_be;
  assign mem_system_data          = s.mem_sys;
  assign code_segment             = s.code_seg;
  assign process_state_word       = s.psw;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_word_direct;
    @(posedge core_clk) disable iff (srst)
    start_ok && !op_indirect && (op_size == SIZE_WORD) |=>
      mem_req && (mem_addr == 16'($past(op_direct_addr) + $past(x_now)));
  endproperty
  a_word_direct: assert property (p_word_direct) // RQ4
    else $error("direct word address wrong");

  property p_byte_direct;
    @(posedge core_clk) disable iff (srst)
    start_ok && !op_indirect && (op_size == SIZE_BYTE) |=>
      (mem_addr == {1'b0, $past(byte_ba[15:1])}) &&
      (!mem_we || (mem_be == ($past(byte_ba[0]) ? 2'h1 : 2'h2)));
  endproperty
  a_byte_direct: assert property (p_byte_direct) // RQ6
    else $error("direct byte address or lane wrong");

  property p_dword_direct;
    @(posedge core_clk) disable iff (srst)
    start_ok && !op_indirect && (op_size == SIZE_DWORD) |=>
      mem_addr == 16'($past(op_direct_addr) + {$past(x_now[14:0]), 1'b0});
  endproperty
  a_dword_direct: assert property (p_dword_direct) // RQ8
    else $error("direct doubleword address wrong");

  // second word only follows the first answer, however late it comes
  property p_dword_next;
    @(posedge core_clk) disable iff (srst)
    (s.fsm == ST_OPND) && mem_ack && (s.size == SIZE_DWORD) |=>
      mem_req && (mem_addr == 16'($past(mem_addr) + 16'h0001));
  endproperty
  a_dword_next: assert property (p_dword_next) // RQ9
    else $error("second doubleword word not at next address");

  property p_ptr_first;
    @(posedge core_clk) disable iff (srst)
    start_ok && op_indirect |=>
      mem_req && !mem_we && (mem_addr == $past(op_direct_addr)) &&
      (s.fsm == ST_PTR);
  endproperty
  a_ptr_first: assert property (p_ptr_first) // RQ21
    else $error("pointer read not issued first");

  property p_ind_word;
    @(posedge core_clk) disable iff (srst)
    (s.fsm == ST_PTR) && mem_ack && (s.size == SIZE_WORD) |=>
      (s.fsm == ST_OPND) &&
      (mem_addr == 16'($past(mem_rdata) + $past(s.index)));
  endproperty
  a_ind_word: assert property (p_ind_word) // RQ5
    else $error("indirect word address wrong");

  property p_push;
    @(posedge core_clk) disable iff (srst)
    (s.fsm == ST_OPND) && mem_ack && !s.store &&
    (s.size != SIZE_DWORD) |=>
      (rp == 3'($past(rp) + 3'h1)) && op_done && !mem_req;
  endproperty
  a_push: assert property (p_push) // RQ12
    else $error("pointer not advanced by one on load");

  property p_dword_pop;
    @(posedge core_clk) disable iff (srst)
    (s.fsm == ST_OPND2) && mem_ack && s.store |=>
      rp == 3'($past(rp) - 3'h2);
  endproperty
  a_dword_pop: assert property (p_dword_pop) // RQ11
    else $error("pointer not lowered by two on store");

  property p_elevated_mode_flag_trap;
    @(posedge core_clk) disable iff (srst)
    ctl_free && op_start && op_privileged && !elevated_mode_flag |=>
      instruction_failure_trap && !mem_req ##1 !instruction_failure_trap;
  endproperty
  a_elevated_mode_flag_trap: assert property (p_elevated_mode_flag_trap) // RQ17
    else $error("privileged operation did not trap");

  property p_callable;
    @(posedge core_clk) disable iff (srst)
    (s.fsm == ST_IDLE) && !intr_start && call_start && call_callable &&
    !call_privileged |=> process_state_word[PSW_ELEVATED_MODE_FLAG];
  endproperty
  a_callable: assert property (p_callable) // RQ18
    else $error("callable procedure not privileged");

  property p_ret;
    @(posedge core_clk) disable iff (srst)
    (s.fsm == ST_IDLE) && !intr_start && !call_start && ret_start |=>
      process_state_word == $past(s.saves[SP_W'(s.save_ptr - 1'b1)]);
  endproperty
  a_ret: assert property (p_ret) // RQ14
    else $error("state word not restored on return");

  property p_data_seg;
    @(posedge core_clk) disable iff (srst)
    start_ok |=>
      mem_system_data == ($past(s.psw[PSW_DS]) | $past(op_system_base));
  endproperty
  a_data_seg: assert property (p_data_seg) // RQ19
    else $error("data segment selection wrong");

  property p_code_seg;
    @(posedge core_clk) disable iff (srst)
    1'b1 |-> code_segment ==
      {process_state_word[PSW_CS], process_state_word[PSW_LS]};
  endproperty
  a_code_seg: assert property (p_code_seg) // RQ20
    else $error("code segment disagrees with state word");

endmodule

/* word_memory.sv */
// data memory model on the far side of the operand port
`timescale 1ns/1ps

module word_memory (
  // clock
  input  wire logic        core_clk,
  // request from the datapath
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  // answer delay chosen by the bench
  input  wire logic [2:0]  delay,
  // answer
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  logic [2:0] waited = 3'h0;

  // contents are a fixed function of the address, lanes differ
  function automatic logic [15:0] mdat(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'hc3a5;
  endfunction

  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0;

  // ****************************************************************
  // answer after the chosen delay
  // ****************************************************************
  // read data inverts every cycle outside a read answer, so stale data matches only on every other cycle
  always @(posedge core_clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      if (waited >= delay)
      begin
        mem_ack <= 1'b1;
        waited <= 3'h0;
        if (!mem_we)
          mem_rdata <= mdat(mem_addr);
      end
      else
        waited <= waited + 3'h1;
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the indexed operand addressing datapath
`timescale 1ns/1ps

module testbench;
  import ioa_pkg::*;
  typedef struct packed {
    logic we; logic sd; logic [1:0] be; logic cw;
    logic [15:0] a; logic [15:0] wd;
  } acc_type;
  logic core_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack, mem_ack;
  logic op_start = 0, op_store = 0, op_indirect = 0, op_system_base = 0;
  logic op_privileged = 0, alu_pop = 0, alu_pop_dword = 0, call_start = 0;
  logic call_callable = 0, call_privileged = 0, ret_start = 0;
  logic intr_start = 0, op_busy, op_done, trap, mem_req, mem_we, mem_sd;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat_wr = 0, dat_rd;
  size_type op_size = SIZE_WORD;
  logic [1:0] op_index_sel = 0, mem_be, code_segment;
  logic [15:0] op_direct_addr = 0, mem_addr, mem_wdata, mem_rdata, psw;
  logic [15:0] xr[1:3], pe = 16'h0007, d;
  logic [2:0] delay = 0, rp = 3'h7;
  logic ds = 0;
  int n_mismatch = 0, check_count = 0, n_trap = 0, seed = 94386, i;
  acc_type mq[$], me;
  logic [15:0] rq[$];

  always #5 core_clk = ~core_clk;

  indexed_operand_addressing u_indexed_operand_addressing (
    .core_clk(core_clk), .srst(srst), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_wr(dat_wr), .dat_rd(dat_rd), .ack(ack),
    .op_start(op_start), .op_store(op_store), .op_indirect(op_indirect),
    .op_size(op_size), .op_index_sel(op_index_sel),
    .op_direct_addr(op_direct_addr), .op_system_base(op_system_base),
    .op_privileged(op_privileged), .alu_pop(alu_pop),
    .alu_pop_dword(alu_pop_dword), .call_start(call_start),
    .call_callable(call_callable), .call_privileged(call_privileged),
    .ret_start(ret_start), .intr_start(intr_start), .op_busy(op_busy),
    .op_done(op_done), .instruction_failure_trap(trap), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_be(mem_be), .mem_system_data(mem_sd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .code_segment(code_segment),
    .process_state_word(psw));

  word_memory u_word_memory (.core_clk(core_clk), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .delay(delay),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic chk(input string nm, input logic [19:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] v);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3;
    dat_wr <= {16'h0, v};
    do @(posedge core_clk); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    wb(1'b0, a, 16'h0);
  endtask

  // ****************************************************************
  // one operand access with its expected memory traffic
  // ****************************************************************
  task automatic op(input logic st, ind, sb, input size_type sz,
                    input logic [1:0] xs, input logic [15:0] da);
    logic [15:0] x, b, v;
    acc_type e;
    x = (xs == 2'h0) ? 16'h0 : xr[xs];
    e = '{we:1'b0, sd:sb | ds, be:2'b11, cw:1'b0, a:da, wd:16'h0};
    if (ind) mq.push_back(e);
    b = ind ? u_word_memory.mdat(da) : {da[14:0], 1'b0};
    e.we = st;
    if (sz == SIZE_BYTE)
    begin
      b = b + x;
      e.a = {1'b0, b[15:1]};
      e.be = b[0] ? 2'b01 : 2'b10;
      v = u_word_memory.mdat(e.a);
      v = b[0] ? {8'h0, v[7:0]} : {8'h0, v[15:8]};
      mq.push_back(e);
    end
    else
    begin
      e.cw = st;
      e.a = (ind ? b : da) + ((sz == SIZE_DWORD) ? {x[14:0], 1'b0} : x);
      e.wd = u_word_memory.mdat(e.a);
      mq.push_back(e);
      if (sz == SIZE_DWORD)
      begin
        e.a = e.a + 16'h1;
        e.wd = u_word_memory.mdat(e.a);
        mq.push_back(e);
      end
      v = e.wd;
    end
    delay <= 3'($random(seed));
    op_start <= 1'b1; op_store <= st; op_indirect <= ind; op_size <= sz;
    op_system_base <= sb; op_index_sel <= xs; op_direct_addr <= da;
    op_privileged <= 1'b0;
    @(posedge core_clk);
    op_start <= 1'b0;
    @(posedge core_clk);
    chk("busy", {19'h0, op_busy}, 20'h1);
    do @(posedge core_clk); while (op_done !== 1'b1);
    chk("busy", {19'h0, op_busy}, 20'h0);
    rp = st ? rp - ((sz == SIZE_DWORD) ? 3'h2 : 3'h1)
            : rp + ((sz == SIZE_DWORD) ? 3'h2 : 3'h1);
    rd(REG_PSW, {pe[15:3], rp});
    if (!st) rd({STACK_PAGE, rp, 2'b00}, v);
  endtask

  task automatic ctl(input int k);
    case (k)
      0: intr_start <= 1'b1;
      1: {call_start, call_callable, call_privileged} <= 3'b110;
      2: {call_start, call_callable, call_privileged} <= 3'b101;
      3: ret_start <= 1'b1;
      4: alu_pop <= 1'b1;
      default:
      begin
        op_start <= 1'b1; op_indirect <= 1'b0; op_store <= 1'b0;
        op_privileged <= (k == 5); op_system_base <= (k == 6);
      end
    endcase
    @(posedge core_clk);
    {intr_start, call_start, ret_start, alu_pop, op_start} <= 5'h0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // monitor: results are compared against the oldest note
  // ****************************************************************
  always @(posedge core_clk)
  begin
    if (trap === 1'b1) n_trap++;
    if (ack === 1'b1 && !we)
      chk("read data", {4'h0, dat_rd[15:0]}, {4'h0, rq.pop_front()});
    if (mem_req === 1'b1 && mem_ack === 1'b1)
    begin
      me = mq.pop_front();
      chk("access", {mem_we, mem_sd, mem_be, mem_addr},
          {me.we, me.sd, me.be, me.a});
      if (me.cw) chk("store data", {4'h0, mem_wdata}, {4'h0, me.wd});
    end
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(REG_PSW, 16'h0007);
    rd(REG_STATUS, 16'h0000);
    rd(8'h10, 16'h0000);
    xr[1] = 16'($random(seed)); xr[2] = 16'hffff; xr[3] = 16'h8000;
    for (i = 1; i < 4; i++) wb(1'b1, {STACK_PAGE, 3'(i + 4), 2'b00}, xr[i]);
    // each load is undone by a store of the same shape
    for (i = 0; i < 24; i++)
    begin
      d = 16'($random(seed));
      op(1'b0, 1'(i / 12), 1'b0, size_type'(i % 3), 2'(i / 3), d);
      op(1'b1, 1'(i / 12), 1'b0, size_type'(i % 3), 2'(i / 3), d);
    end
    $display("test indexing done");
    ctl(5); ctl(6); ctl(2);
    ctl(1);
    chk("elevated", {19'h0, psw[PSW_ELEVATED_MODE_FLAG]}, 20'h1);
    ctl(3);
    chk("state word", {4'h0, psw}, 20'h0007);
    ctl(0);
    chk("state word", {4'h0, psw}, 20'h0707);
    chk("code segment", {18'h0, code_segment}, 20'h2);
    ds = 1'b1; pe = 16'h0707;
    op(1'b0, 1'b0, 1'b1, SIZE_WORD, 2'h1, d);
    op(1'b1, 1'b0, 1'b1, SIZE_WORD, 2'h1, d);
    ctl(3);
    ds = 1'b0; pe = 16'h0007;
    chk("state word", {4'h0, psw}, 20'h0007);
    chk("traps", 20'(n_trap), 20'h3);
    $display("test privilege done");
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, REG_PSW, {4'h0, i[0], 2'b00, i[1], 8'h07});
      @(posedge core_clk);
      chk("code segment", {18'h0, code_segment}, 20'(i));
    end
    wb(1'b1, REG_PSW, 16'h0007);
    ctl(4);
    rd(REG_PSW, 16'h0006);
    alu_pop_dword <= 1'b1;
    ctl(4);
    rd(REG_PSW, 16'h0004);
    alu_pop_dword <= 1'b0;
    wb(1'b1, REG_PSW, 16'h0000);
    ctl(4);
    rd(REG_PSW, 16'h0007);
    $display("test pointer done");
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
